// ===== rtl/rx_los_consts.vh
`ifndef RX_LOS_CONSTS_VH
`define RX_LOS_CONSTS_VH

// Register bus geometry
`define AXI_ADDR_W       8
`define AXI_DATA_W       32

// Register byte offsets
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_CONFIG      8'h08

// Field positions
`define CTRL_FSM_EN_BIT  0
`define CFG_DECAY_LSB    0
`define CFG_THRESH_LSB   8
`define STS_STATE_LSB    0
`define STS_MODE_BIT     2
`define STS_ALIGN_BIT    3
`define STS_COUNT_LSB    16

// Field widths
`define CODE_W           3
`define CNT_W            11

// Reset values (decay code is log2 of the ratio, threshold code is log2 of the threshold minus two)
`define RST_FSM_EN       1'b1
`define RST_DECAY_LOG    3'h2
`define RST_THRESH_LOG   3'h3

// Threshold code 0 means 4, i.e. one shifted left by two
`define THRESH_BASE_LOG  4'h2

// State_unlocked machine states
`define ST_UNLOCKED      2'h0
`define ST_RESYNC        2'h1
`define ST_LOCKED        2'h2

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ===== rtl/los_error_counter.v
`timescale 1ns/10ps
`include "rx_los_consts.vh"

module los_error_counter (
   input  wire                  clk_in,        // Receive user clock
   input  wire                  resetn_in,     // Synchronous, active low
   input  wire                  clear_in,      // Hold count at zero
   input  wire [1:0]            bad_cnt_in,    // Invalid bytes this cycle
   input  wire [1:0]            good_cnt_in,   // Valid bytes this cycle
   input  wire [`CODE_W-1:0]    decay_log_in,  // log2 of decay ratio
   input  wire [`CODE_W-1:0]    thresh_log_in, // Threshold code
   output wire [`CNT_W-1:0]     count_out,     // Present error count
   output wire                  limit_hit_out  // Count reaches threshold
);

reg  [`CNT_W-1:0] count_reg;
reg  [`CNT_W-1:0] count_next;
wire [`CNT_W-1:0] incr;
wire [`CNT_W-1:0] thresh;
wire [`CNT_W-1:0] sum;
wire [`CNT_W-1:0] drained;
wire [3:0]        thresh_shift;

////////////////////////////////////////////////////////////////////////////
// Each invalid byte weighs the decay ratio, each valid byte drains one
assign incr         = {{(`CNT_W-2){1'b0}}, bad_cnt_in} <<
                      decay_log_in;
assign thresh_shift = {1'b0, thresh_log_in} + `THRESH_BASE_LOG;
assign thresh       = {{(`CNT_W-1){1'b0}}, 1'b1} << thresh_shift;
assign sum          = count_reg + incr;
// Floor at zero so a long clean run cannot bank credit
assign drained      = (sum > {{(`CNT_W-2){1'b0}}, good_cnt_in}) ?
                      sum - {{(`CNT_W-2){1'b0}}, good_cnt_in} :
                      {`CNT_W{1'b0}};
assign limit_hit_out = (drained >= thresh);
assign count_out     = count_reg;

// Saturate at the threshold; the owner clears on leaving lock
always @* begin
   if (clear_in) begin
      count_next = {`CNT_W{1'b0}};
   end else if (limit_hit_out) begin
      count_next = thresh;
   end else begin
      count_next = drained;
   end
end

// Count register
always @(posedge clk_in) begin
   if (!resetn_in) begin
      count_reg <= {`CNT_W{1'b0}};
   end else begin
      count_reg <= count_next;
   end
end

endmodule

// ===== rtl/rx_state_unlocked_monitor.v
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "rx_los_consts.vh"

// Overview of operation
// - Two-bit sync status output, meaning set by the machine enable.
// - Machine mode: bit one high while sync is lost, errors or reset.
// - Machine mode: bit zero high in resync, after bonding or realign.
// - Monitor mode: bit one high on invalid code or disparity error.
// - Monitor mode: bit zero high when bonding sequence is buffered.
// - Enable bit picks machine or monitor mode; machine by default.
// - Decay ratio: valid characters cancelling one invalid; 1 to 128.
// - Threshold over decay gives invalid characters to lose sync.
// - While locked, valid characters drain the error count at decay rate.
// - Locked and unlocked states exist and always show in machine mode.
// - Realign arrives as a one-cycle pulse from the comma aligner.
// - Invalid-code flag is per byte, from the decoder.
module rx_state_unlocked_monitor (
   input  wire                  ref_clk_in,              // 40 MHz clock
   input  wire                  resetn_in,               // Sync, active low
   // AXI4-Lite slave
   input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr_in,        // Write address
   input  wire                  s_axi_awvalid_in,        // Write addr valid
   output wire                  s_axi_awready_out,       // Write addr ready
   input  wire [`AXI_DATA_W-1:0] s_axi_wdata_in,         // Write data
   input  wire [3:0]            s_axi_wstrb_in,          // Byte strobes
   input  wire                  s_axi_wvalid_in,         // Write data valid
   output wire                  s_axi_wready_out,        // Write data ready
   output wire [1:0]            s_axi_bresp_out,         // Write response
   output wire                  s_axi_bvalid_out,        // Response valid
   input  wire                  s_axi_bready_in,         // Response ready
   input  wire [`AXI_ADDR_W-1:0] s_axi_araddr_in,        // Read address
   input  wire                  s_axi_arvalid_in,        // Read addr valid
   output wire                  s_axi_arready_out,       // Read addr ready
   output wire [`AXI_DATA_W-1:0] s_axi_rdata_out,        // Read data
   output wire [1:0]            s_axi_rresp_out,         // Read response
   output wire                  s_axi_rvalid_out,        // Read data valid
   input  wire                  s_axi_rready_in,         // Read data ready
   // Decoded character stream
   input  wire [1:0]            char_valid_in,           // Byte present
   input  wire [1:0]            invalid_code_flag_in,    // Not in code table
   input  wire [1:0]            disparity_error_flag_in, // Disparity error
   input  wire                  realign_pulse_in,        // Comma realigned
   input  wire                  bond_seq_in,             // Bond seq buffered
   input  wire                  byte_aligned_in,         // Comma aligned
   // Status
   output wire [1:0]            sync_status_out          // Sync status
);

////////////////////////////////////////////////////////////////////////////
// Declarations

reg                   awready_reg;
reg                   wready_reg;
reg                   bvalid_reg;
reg  [1:0]            bresp_reg;
reg                   arready_reg;
reg                   rvalid_reg;
reg  [1:0]            rresp_reg;
reg  [`AXI_DATA_W-1:0] rdata_reg;
reg                   aw_have_reg;
reg                   w_have_reg;
reg  [`AXI_ADDR_W-1:0] waddr_reg;
reg  [`AXI_DATA_W-1:0] wdata_reg;
reg  [3:0]            wstrb_reg;

reg                   sync_fsm_enable_reg;
reg  [`CODE_W-1:0]    error_decay_ratio_reg;
reg  [`CODE_W-1:0]    error_threshold_reg;

reg  [1:0]            state_reg;
reg  [1:0]            state_next;
reg  [1:0]            sync_status_reg;
reg  [1:0]            sync_status_next;

wire [1:0]            byte_bad;
wire [1:0]            byte_good;
wire [1:0]            bad_cnt;
wire [1:0]            good_cnt;
wire                  bad_any;
wire                  good_any;
wire [`CNT_W-1:0]     err_count;
wire                  limit_hit;
wire                  count_clear;
wire                  do_write;
wire [`AXI_DATA_W-1:0] status_word;
wire [`AXI_DATA_W-1:0] config_word;
wire [`AXI_DATA_W-1:0] ctrl_word;

////////////////////////////////////////////////////////////////////////////
// Address decode, shared by the write and the read path

function addr_known;
   input [`AXI_ADDR_W-1:0] addr;
   begin
      addr_known = (addr == `ADDR_CTRL) || (addr == `ADDR_STATUS) ||
                   (addr == `ADDR_CONFIG);
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// Per-byte character classification

genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1) begin : g_byte
      // Disparity errors are treated as invalid characters too
      assign byte_bad[gi]  = char_valid_in[gi] &
                             (invalid_code_flag_in[gi] |
                              disparity_error_flag_in[gi]);
      assign byte_good[gi] = char_valid_in[gi] & ~byte_bad[gi];
   end
endgenerate

// Number of bad and good bytes in this word
assign bad_cnt  = {byte_bad[1] & byte_bad[0], byte_bad[1] ^ byte_bad[0]};
assign good_cnt = {byte_good[1] & byte_good[0],
                   byte_good[1] ^ byte_good[0]};
assign bad_any  = |byte_bad;
assign good_any = |byte_good;

////////////////////////////////////////////////////////////////////////////
// Error accumulator, only counts while locked

assign count_clear = (state_reg != `ST_LOCKED);

los_error_counter u_err_cnt (
   .clk_in        (ref_clk_in),
   .resetn_in     (resetn_in),
   .clear_in      (count_clear),
   .bad_cnt_in    (bad_cnt),
   .good_cnt_in   (good_cnt),
   .decay_log_in  (error_decay_ratio_reg),
   .thresh_log_in (error_threshold_reg),
   .count_out     (err_count),
   .limit_hit_out (limit_hit)
);

////////////////////////////////////////////////////////////////////////////
// State_unlocked state machine

// The machine runs in both modes so a switch back shows live state
always @* begin
   state_next = state_reg;
   case (state_reg)
      `ST_UNLOCKED: begin
         // Leave only on a clean aligned word
         if (byte_aligned_in && good_any && !bad_any) begin
            state_next = `ST_RESYNC;
         end
      end
      `ST_RESYNC: begin
         if (bad_any || !byte_aligned_in) begin
            state_next = `ST_UNLOCKED;
         end else if (good_any && !realign_pulse_in && !bond_seq_in) begin
            state_next = `ST_LOCKED;
         end
      end
      `ST_LOCKED: begin
         // Errors win over a coincident realign
         if (limit_hit) begin
            state_next = `ST_UNLOCKED;
         end else if (realign_pulse_in || bond_seq_in) begin
            state_next = `ST_RESYNC;
         end
      end
      default: begin
         state_next = `ST_UNLOCKED;
      end
   endcase
end

// State register
always @(posedge ref_clk_in) begin
   if (!resetn_in) begin
      state_reg <= `ST_UNLOCKED;
   end else begin
      state_reg <= state_next;
   end
end

////////////////////////////////////////////////////////////////////////////
// Status output, one register stage after the cause

always @* begin
   if (sync_fsm_enable_reg) begin
      // Machine mode mirrors the state being entered
      sync_status_next[1] = (state_next == `ST_UNLOCKED);
      sync_status_next[0] = (state_next == `ST_RESYNC);
   end else begin
      // Monitor mode flags the present word only
      sync_status_next[1] = bad_any;
      sync_status_next[0] = bond_seq_in;
   end
end

// Reset shows lost sync, matching the reset state
always @(posedge ref_clk_in) begin
   if (!resetn_in) begin
      sync_status_reg <= 2'h2;
   end else begin
      sync_status_reg <= sync_status_next;
   end
end

assign sync_status_out = sync_status_reg;

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel

// Address and data may come in either order; write when both are held
assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

always @(posedge ref_clk_in) begin
   if (!resetn_in) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      waddr_reg   <= {`AXI_ADDR_W{1'b0}};
      wdata_reg   <= {`AXI_DATA_W{1'b0}};
      wstrb_reg   <= 4'h0;
   end else begin
      if (s_axi_awvalid_in && awready_reg) begin
         awready_reg <= 1'b0;
         aw_have_reg <= 1'b1;
         waddr_reg   <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && wready_reg) begin
         wready_reg <= 1'b0;
         w_have_reg <= 1'b1;
         wdata_reg  <= s_axi_wdata_in;
         wstrb_reg  <= s_axi_wstrb_in;
      end
      if (do_write) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         bvalid_reg  <= 1'b1;
         bresp_reg   <= addr_known(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Ready returns only after the response, one write at a time
      if (bvalid_reg && s_axi_bready_in) begin
         bvalid_reg  <= 1'b0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
      end
   end
end

// Writable settings; status is read-only and ignores writes
always @(posedge ref_clk_in) begin
   if (!resetn_in) begin
      sync_fsm_enable_reg   <= `RST_FSM_EN;
      error_decay_ratio_reg <= `RST_DECAY_LOG;
      error_threshold_reg   <= `RST_THRESH_LOG;
   end else if (do_write) begin
      if (waddr_reg == `ADDR_CTRL && wstrb_reg[0]) begin
         sync_fsm_enable_reg <= wdata_reg[`CTRL_FSM_EN_BIT];
      end
      if (waddr_reg == `ADDR_CONFIG && wstrb_reg[0]) begin
         error_decay_ratio_reg <=
            wdata_reg[`CFG_DECAY_LSB +: `CODE_W];
      end
      if (waddr_reg == `ADDR_CONFIG && wstrb_reg[1]) begin
         error_threshold_reg <=
            wdata_reg[`CFG_THRESH_LSB +: `CODE_W];
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel

assign ctrl_word   = {{(`AXI_DATA_W-1){1'b0}}, sync_fsm_enable_reg};
assign config_word = {{(`AXI_DATA_W-11){1'b0}}, error_threshold_reg,
                      5'h00, error_decay_ratio_reg};
assign status_word = {{(`AXI_DATA_W-`STS_COUNT_LSB-`CNT_W){1'b0}},
                      err_count, 12'h000, byte_aligned_in,
                      sync_fsm_enable_reg, state_reg};

// Unmapped reads return zero with a slave error
always @(posedge ref_clk_in) begin
   if (!resetn_in) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `RESP_OKAY;
      rdata_reg   <= {`AXI_DATA_W{1'b0}};
   end else begin
      if (s_axi_arvalid_in && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rresp_reg   <= addr_known(s_axi_araddr_in) ? `RESP_OKAY :
                        `RESP_SLVERR;
         case (s_axi_araddr_in)
            `ADDR_CTRL:   rdata_reg <= ctrl_word;
            `ADDR_STATUS: rdata_reg <= status_word;
            `ADDR_CONFIG: rdata_reg <= config_word;
            default:      rdata_reg <= {`AXI_DATA_W{1'b0}};
         endcase
      end
      if (rvalid_reg && s_axi_rready_in) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end
end

// Bus outputs straight from their registers
assign s_axi_awready_out = awready_reg;
assign s_axi_wready_out  = wready_reg;
assign s_axi_bvalid_out  = bvalid_reg;
assign s_axi_bresp_out   = bresp_reg;
assign s_axi_arready_out = arready_reg;
assign s_axi_rvalid_out  = rvalid_reg;
assign s_axi_rresp_out   = rresp_reg;
assign s_axi_rdata_out   = rdata_reg;

endmodule

// ===== dv/char_feed.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////
// Decoded character source standing in for decoder and comma aligner
module char_feed (
   input  wire logic  clk_in,      // Receive user clock
   output logic [1:0] valid_out,   // Byte present
   output logic [1:0] inv_out,     // Not in code table
   output logic [1:0] disp_out,    // Disparity error
   output logic       realign_out, // Realign pulse
   output logic       bond_out,    // Bond sequence buffered
   output logic       aligned_out  // Comma alignment held
);
   // Flags stay high on absent bytes, so ungated error logic shows up
   task automatic idle_w();
      valid_out   <= 2'h0;
      inv_out     <= 2'h3;
      disp_out    <= 2'h3;
      realign_out <= 1'b0;
      bond_out    <= 1'b0;
   endtask
   initial begin
      aligned_out <= 1'b0;
      idle_w();
   end
   // One word per cycle for n cycles; ev is realign, bond, aligned
   task automatic send(input logic [1:0] v, i, d, input logic [2:0] ev,
                       input int n);
      repeat (n) begin
         @(posedge clk_in);
         valid_out   <= v;
         inv_out     <= i;
         disp_out    <= d;
         realign_out <= ev[2] & ~realign_out;
         bond_out    <= ev[1];
         aligned_out <= ev[0];
      end
      @(posedge clk_in);
      idle_w();
   endtask
endmodule

// ===== dv/los_sva.sv
`timescale 1ns/10ps
`include "rx_los_consts.vh"
module los_sva (
   input wire                   ref_clk_in,              // Clock
   input wire                   resetn_in,               // Reset
   input wire [`AXI_ADDR_W-1:0] s_axi_awaddr_in,         // Write addr
   input wire                   s_axi_awvalid_in,        // Addr valid
   input wire                   s_axi_awready_out,       // Addr ready
   input wire [`AXI_DATA_W-1:0] s_axi_wdata_in,          // Write data
   input wire [3:0]             s_axi_wstrb_in,          // Strobes
   input wire                   s_axi_wvalid_in,         // Data valid
   input wire                   s_axi_wready_out,        // Data ready
   input wire                   s_axi_bvalid_out,        // Resp valid
   input wire                   s_axi_bready_in,         // Resp ready
   input wire [1:0]             char_valid_in,           // Byte present
   input wire [1:0]             invalid_code_flag_in,    // Bad code
   input wire [1:0]             disparity_error_flag_in, // Bad disparity
   input wire                   realign_pulse_in,        // Realigned
   input wire                   bond_seq_in,             // Bond sequence
   input wire                   byte_aligned_in,         // Aligned
   input wire [1:0]             sync_status_out          // Status
);
   // Mode follows finished control writes; it lands one edge after the
   // write, so mode checks skip cycles with a response pending
   reg [`AXI_ADDR_W-1:0] wa_reg;
   reg                   wd_reg;
   reg                   ws_reg;
   reg                   mon_reg;
   wire [1:0] bad = char_valid_in &
                    (invalid_code_flag_in | disparity_error_flag_in);
   wire       good = (char_valid_in == 2'h3) && (bad == 2'h0);
   wire       calm = !realign_pulse_in && !bond_seq_in;
   wire       fsm = !mon_reg && !s_axi_bvalid_out;
   wire       mon = mon_reg && !s_axi_bvalid_out;
   wire [1:0] st = sync_status_out;
   wire       bad_any = |bad;
   always @(posedge ref_clk_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out)
         wa_reg <= s_axi_awaddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out) begin
         wd_reg <= s_axi_wdata_in[`CTRL_FSM_EN_BIT];
         ws_reg <= s_axi_wstrb_in[0];
      end
      if (!resetn_in)
         mon_reg <= 1'b0;
      else if (s_axi_bvalid_out && s_axi_bready_in && ws_reg &&
               wa_reg == `ADDR_CTRL)
         mon_reg <= !wd_reg;
   end
   //////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   property p_rst; $rose(resetn_in) |-> st == 2'h2; endproperty
   property p_mbad; mon |-> st[1] == $past(bad_any); endproperty
   property p_mbond; mon |-> st[0] == $past(bond_seq_in); endproperty
   property p_no3; fsm |-> st != 2'h3; endproperty
   property p_evt;
      fsm && st == 2'h0 && bad == 2'h0 && !calm |=> st == 2'h1;
   endproperty
   property p_hold; fsm && st == 2'h2 && !byte_aligned_in |=> st == 2'h2;
   endproperty
   property p_noskip; fsm && st == 2'h2 |=> st != 2'h0; endproperty
   property p_rsbad; fsm && st == 2'h1 && bad != 2'h0 |=> st == 2'h2;
   endproperty
   property p_lock;
      fsm && st == 2'h1 && good && byte_aligned_in && calm |=> st == 2'h0;
   endproperty
   property p_keep; fsm && st == 2'h0 && bad == 2'h0 && calm |=> !st[1];
   endproperty
   a_rst: assert property (p_rst)
      else $error("status not lost after reset");
   a_mbad: assert property (p_mbad)
      else $error("monitor bad flag wrong");
   a_mbond: assert property (p_mbond)
      else $error("monitor bond flag wrong");
   a_no3: assert property (p_no3)
      else $error("illegal state code");
   a_evt: assert property (p_evt)
      else $error("event did not enter resync");
   a_hold: assert property (p_hold)
      else $error("left unlocked without alignment");
   a_noskip: assert property (p_noskip)
      else $error("unlocked went straight to locked");
   a_rsbad: assert property (p_rsbad)
      else $error("bad byte in resync kept sync");
   a_lock: assert property (p_lock)
      else $error("good word in resync did not lock");
   a_keep: assert property (p_keep)
      else $error("error-free word lost sync");
   c_lost: cover property (fsm && st == 2'h0 ##1 st == 2'h2);
   c_evt: cover property (fsm && st == 2'h0 ##1 st == 2'h1);
   c_mon: cover property (mon && st == 2'h1);
endmodule
bind rx_state_unlocked_monitor los_sva i_sva (
   .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
   .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
   .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
   .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
   .s_axi_wready_out(s_axi_wready_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_bvalid_out(s_axi_bvalid_out), .char_valid_in(char_valid_in),
   .invalid_code_flag_in(invalid_code_flag_in),
   .disparity_error_flag_in(disparity_error_flag_in),
   .realign_pulse_in(realign_pulse_in), .bond_seq_in(bond_seq_in),
   .byte_aligned_in(byte_aligned_in), .sync_status_out(sync_status_out));

// ===== dv/rx_state_unlocked_monitor_tb.sv
`timescale 1ns/10ps
`include "rx_los_consts.vh"
`define CHK(n, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("mismatch %s exp %0h got %0h", n, e, g); \
   end \
end
module rx_state_unlocked_monitor_tb;
   logic        clk;
   logic        rstn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, rl, bs, al;
   wire [1:0]   bresp, rresp, cv, ci, cd, st;
   wire [31:0]  rdata;
   logic [31:0] rd_d;
   logic [1:0]  rsp;
   int          errors = 0;
   int          tests_run = 0;
   int          n;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   rx_state_unlocked_monitor i_dut (
      .ref_clk_in(clk), .resetn_in(rstn),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .char_valid_in(cv),
      .invalid_code_flag_in(ci), .disparity_error_flag_in(cd),
      .realign_pulse_in(rl), .bond_seq_in(bs), .byte_aligned_in(al),
      .sync_status_out(st));
   char_feed i_feed (.clk_in(clk), .valid_out(cv), .inv_out(ci),
      .disp_out(cd), .realign_out(rl), .bond_out(bs), .aligned_out(al));
   //////////////////////////////////////////////////////////////////////
   // Both write channels offered at once, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rd_d = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // Status is sampled just after the edge, once its update has landed
   task automatic ck_st(input logic [1:0] e);
      #1;
      `CHK("sync_status", e, st)
   endtask
   task automatic summarize();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // A hang far past the expected run length ends the test
   initial begin
      #(25 * 6000);
      errors++;
      summarize();
   end
   //////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      ck_st(2'h2);
      rd(`ADDR_STATUS);
      `CHK("status_reg", 32'h0000_0004, rd_d)
      rd(`ADDR_CONFIG);
      `CHK("config_reg", 32'h0000_0302, rd_d)
      rd(8'h0C);
      `CHK("rresp", `RESP_SLVERR, rsp)
      `CHK("rdata", 32'h0, rd_d)
      wr(8'h0C, 32'hFFFF_FFFF, 4'hF);
      `CHK("bresp", `RESP_SLVERR, rsp)
      wr(`ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
      rd(`ADDR_STATUS);
      `CHK("status_ro", 32'h0000_0004, rd_d)
      wr(`ADDR_CONFIG, 32'h0000_0701, 4'h1);
      wr(`ADDR_CONFIG, 32'h0000_0502, 4'h2);
      rd(`ADDR_CONFIG);
      `CHK("config_strb", 32'h0000_0501, rd_d)
      wr(`ADDR_CONFIG, 32'h0000_0302, 4'hF);
      // Lock, then 6 bad bytes at 4 each, 8 good, then disparity errors
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 1);
      ck_st(2'h1);
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 1);
      ck_st(2'h0);
      i_feed.send(2'h3, 2'h3, 2'h0, 3'h1, 3);
      rd(`ADDR_STATUS);
      `CHK("count", 32'h0018_000E, rd_d)
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 4);
      rd(`ADDR_STATUS);
      `CHK("count", 32'h0010_000E, rd_d)
      i_feed.send(2'h3, 2'h0, 2'h3, 3'h1, 2);
      ck_st(2'h2);
      rd(`ADDR_STATUS);
      `CHK("count", 32'h0000_000C, rd_d)
      // Every decay and threshold code, one bad byte per word
      for (int k = 0; k < 8; k++) begin
         n = (k > 4) ? 1 : (1 << (9 - 2 * k));
         wr(`ADDR_CONFIG, 32'(((7 - k) << 8) | k), 4'hF);
         i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 2);
         ck_st(2'h0);
         if (n > 1) begin
            i_feed.send(2'h1, 2'h1, 2'h0, 3'h1, n - 1);
            ck_st(2'h0);
         end
         i_feed.send(2'h2, 2'h2, 2'h0, 3'h1, 1);
         ck_st(2'h2);
      end
      wr(`ADDR_CONFIG, 32'h0000_0302, 4'hF);
      // Realign and bonding force resync; errors drop it, lost alignment holds unlocked
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 2);
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h5, 1);
      ck_st(2'h1);
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 1);
      ck_st(2'h0);
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h3, 1);
      ck_st(2'h1);
      i_feed.send(2'h3, 2'h1, 2'h0, 3'h1, 1);
      ck_st(2'h2);
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h0, 3);
      ck_st(2'h2);
      // Monitor mode shows raw flags a cycle later
      wr(`ADDR_CTRL, 32'h0, 4'hF);
      rd(`ADDR_STATUS);
      `CHK("status_mon", 32'h0, rd_d)
      i_feed.send(2'h2, 2'h2, 2'h0, 3'h0, 1);
      ck_st(2'h2);
      i_feed.send(2'h1, 2'h0, 2'h1, 3'h0, 1);
      ck_st(2'h2);
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h2, 1);
      ck_st(2'h1);
      @(posedge clk);
      ck_st(2'h0);
      wr(`ADDR_CTRL, 32'h1, 4'hF);
      ck_st(2'h2);
      // Reset in mid-run from lock restores defaults
      i_feed.send(2'h3, 2'h0, 2'h0, 3'h1, 2);
      wr(`ADDR_CTRL, 32'h0, 4'hF);
      wr(`ADDR_CONFIG, 32'h0000_0100, 4'hF);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      ck_st(2'h2);
      rd(`ADDR_CTRL);
      `CHK("ctrl_reset", 32'h1, rd_d)
      rd(`ADDR_CONFIG);
      `CHK("config_reset", 32'h0000_0302, rd_d)
      summarize();
   end
endmodule
